//--- rtl/rsq_pkg.sv
// Functional notes
// - Power-on reset on supply rise; delay counts from oscillator start.
// - Start-up timeout is a build choice: 4064 cycles or 2 cycles.
// - Short-startup select forces the 2-cycle timeout on stop exit only.
// - Pin still low after timeout keeps the core in reset until high.
// - Reset clears prescaler, presets counter FFFC, clears compare bits, enables.
// - Reset clears directions, sets stack to 00FF, fetches 1FFE, sets mask.
// - Reset clears stop, external and wait latches; pin reset still times out.
// - Reset disables serial port and clears its enables, role and flags.
// - Reset stops timer oscillator, clears keypad enable, open-drain and short select.
// - Four maskable sources plus one unmaskable software trap.
// - Cleared enable blocks the request but the flag still sets.
// - Flag clears after status access while set, then associated access.
// - Enabled unmasked request taken at instruction end, or at once while waiting; stack, mask, vector.
// - Return from trap restores mask from its stacked value.
// - Priority: reset, trap, external pin, timer, serial, keypad.
// - Vectors: reset 1FFE, software trap 1FFC, external pin 1FFA.
// - Vectors: timer 1FF8, serial 1FF4, keypad 1FF2.
// - External request latched while masked; latch clears early in service.
package rsq_pkg;

	localparam int TMO_LONG_CYC  = 4064;
	localparam int TMO_SHORT_CYC = 2;

	localparam logic [12:0] VEC_RESET  = 13'h1FFE;
	localparam logic [12:0] VEC_SWI    = 13'h1FFC;
	localparam logic [12:0] VEC_EXT    = 13'h1FFA;
	localparam logic [12:0] VEC_TIMER  = 13'h1FF8;
	localparam logic [12:0] VEC_SERIAL = 13'h1FF4;
	localparam logic [12:0] VEC_KEYPAD = 13'h1FF2;
	localparam logic [12:0] SP_RESET   = 13'h00FF;
	localparam logic [15:0] TMR_COUNTER_RESET = 16'hFFFC;
	localparam logic [7:0]  DDR_RESET  = 8'h00;

	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_FLAGS  = 8'h04;
	localparam logic [7:0]  ADDR_ACK    = 8'h08;
	localparam logic [7:0]  ADDR_STATUS = 8'h0C;
	localparam logic [31:0] RDATA_NONE  = 32'h0000_0000;

	typedef struct packed {
		logic short_startup_select;
		logic keypad_irq_enable;
		logic port_a_open_drain_select;
		logic port_d_open_drain_select;
		logic ext_timer_osc_enable;
		logic serial_port_enable;
		logic serial_irq_enable;
		logic controller_role_select;
		logic capture_irq_enable;
		logic compare_irq_enable;
		logic overflow_irq_enable;
		logic compare_output_level;
		logic compare_output_bit;
	} rsq_ctrl_t;

	typedef struct packed {
		logic capture_event_flag;
		logic compare_match_flag;
		logic counter_overflow_flag;
		logic transfer_done_flag;
		logic write_collision_flag;
		logic mode_fault_flag;
		logic keypad_port_flag;
	} rsq_flags_t;

	localparam rsq_ctrl_t  CTRL_RESET  = '0;
	localparam rsq_flags_t FLAGS_RESET = '0;
	localparam int CTRL_W  = $bits(rsq_ctrl_t);
	localparam int FLAGS_W = $bits(rsq_flags_t);

	typedef enum logic [5:0] {
		S_OSC      = 6'b00_0001,
		S_RST_TMO  = 6'b00_0010,
		S_HOLD     = 6'b00_0100,
		S_RUN      = 6'b00_1000,
		S_STOP     = 6'b01_0000,
		S_STOP_TMO = 6'b10_0000
	} rsq_state_t;

endpackage

//--- rtl/rsq_startup_timer.sv
module rsq_startup_timer
	import rsq_pkg::*;
#(
	parameter int LONG_CYC  = TMO_LONG_CYC,
	parameter int SHORT_CYC = TMO_SHORT_CYC,
	parameter int CW        = 13
)(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic start,
	input  wire logic short_sel,
	output logic      busy,
	output logic      done
);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic          next_busy;
	logic          next_done;

	// Done pulses exactly the chosen count of cycles after start
	always_comb
	begin
		next_cnt  = cnt;
		next_busy = busy;
		next_done = 1'b0;
		if (start)
		begin
			next_busy = 1'b1;
			next_cnt  = short_sel ? CW'(SHORT_CYC - 1) : CW'(LONG_CYC - 1);
		end
		else if (busy)
		begin
			if (cnt == '0)
			begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
			else
				next_cnt = cnt - CW'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt  <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			cnt  <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end

endmodule

//--- rtl/rsq_top.sv
// The register addresses and the AHB-Lite register port were left to the implementer.
module rsq_top
	import rsq_pkg::*;
#(
	parameter bit LONG_STARTUP = 1'b1,
	parameter bit LEVEL_IRQ    = 1'b1,
	parameter int LONG_CYC     = TMO_LONG_CYC
)(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        ext_reset_n,
	input  wire logic        irq_n,
	input  wire logic        osc_active,
	input  wire rsq_flags_t  periph_events,
	input  wire logic        insn_boundary,
	input  wire logic        swi_exec,
	input  wire logic        rti_exec,
	input  wire logic        rti_stacked_i,
	input  wire logic        stop_enter,
	input  wire logic        wait_enter,
	output logic             core_reset,
	output logic             i_mask,
	output logic             irq_take,
	output logic [12:0]      irq_vector,
	output logic             core_sleep,
	output logic [12:0]      stack_ptr_init,
	output logic [15:0]      tmr_counter_preset,
	output logic [7:0]       ddr_preset,
	output rsq_ctrl_t        ctrl,
	output rsq_flags_t       flags
);

	////////////////////////////////////////////////////////////////////////
	// Sequencer state

	rsq_state_t  state, next_state;
	logic        ext_latch, next_ext_latch;
	logic        stop_latch, next_stop_latch;
	logic        wait_latch, next_wait_latch;
	logic        next_core_reset, next_i_mask, next_irq_take;
	logic [12:0] next_irq_vector;
	logic        irq_q, tmo_short, next_tmo_short;
	logic        tmr_start, tmr_short, tmr_busy, tmr_done;
	logic        irq_edge, timer_req, serial_req, keypad_req, stop_wake;
	logic        req_any;
	logic [12:0] req_vec;

	// Highest maskable request wins; trap and reset are handled outside
	function automatic logic [13:0] pick_request(input logic ext,
		input logic tmr, input logic ser, input logic key);
		if (ext)
			return {1'b1, VEC_EXT};
		else if (tmr)
			return {1'b1, VEC_TIMER};
		else if (ser)
			return {1'b1, VEC_SERIAL};
		else if (key)
			return {1'b1, VEC_KEYPAD};
		return {1'b0, VEC_RESET};
	endfunction

	rsq_startup_timer #(
		.LONG_CYC  (LONG_CYC),
		.SHORT_CYC (TMO_SHORT_CYC),
		.CW        (13)
	) u_timer (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.start     (tmr_start),
		.short_sel (tmr_short),
		.busy      (tmr_busy),
		.done      (tmr_done)
	);

	always_comb
	begin
		next_state      = state;
		next_i_mask     = i_mask;
		next_ext_latch  = ext_latch;
		next_stop_latch = stop_latch;
		next_wait_latch = wait_latch;
		next_irq_take   = 1'b0;
		next_irq_vector = irq_vector;
		tmr_start       = 1'b0;
		tmr_short       = !LONG_STARTUP;
		// Level option keeps re-latching while a wired-OR line stays low
		irq_edge   = LEVEL_IRQ ? !irq_n : (irq_q && !irq_n);
		timer_req  = (flags.capture_event_flag && ctrl.capture_irq_enable)
			|| (flags.compare_match_flag && ctrl.compare_irq_enable)
			|| (flags.counter_overflow_flag && ctrl.overflow_irq_enable);
		serial_req = (flags.transfer_done_flag || flags.mode_fault_flag)
			&& ctrl.serial_irq_enable;
		keypad_req = flags.keypad_port_flag && ctrl.keypad_irq_enable;
		{req_any, req_vec} = pick_request(ext_latch, timer_req,
			serial_req, keypad_req);
		// Timer wakes stop only when it runs from its own oscillator
		stop_wake = ext_latch || irq_edge || keypad_req
			|| (timer_req && ctrl.ext_timer_osc_enable);
		case (state)
			S_OSC:
				if (osc_active)
				begin
					tmr_start  = 1'b1;
					next_state = S_RST_TMO;
				end
			S_RST_TMO:
				if (tmr_done)
					next_state = ext_reset_n ? S_RUN : S_HOLD;
			S_HOLD:
				if (ext_reset_n)
					next_state = S_RUN;
			S_RUN:
				if (stop_enter)
				begin
					next_stop_latch = 1'b1;
					next_state      = S_STOP;
				end
				else if (rti_exec)
					next_i_mask = rti_stacked_i;
				else if (insn_boundary && swi_exec)
				begin
					next_irq_take   = 1'b1;
					next_irq_vector = VEC_SWI;
					next_i_mask     = 1'b1;
					next_wait_latch = 1'b0;
				end
				else if ((insn_boundary || wait_latch) && !i_mask && req_any)
				begin
					next_irq_take   = 1'b1;
					next_irq_vector = req_vec;
					next_i_mask     = 1'b1;
					next_wait_latch = 1'b0;
					if (req_vec == VEC_EXT)
						next_ext_latch = 1'b0;
				end
				else if (wait_enter)
					next_wait_latch = 1'b1;
			S_STOP:
				if (stop_wake)
				begin
					tmr_start  = 1'b1;
					tmr_short  = ctrl.short_startup_select || !LONG_STARTUP;
					next_state = S_STOP_TMO;
				end
			S_STOP_TMO:
				if (tmr_done)
				begin
					next_stop_latch = 1'b0;
					next_state      = S_RUN;
				end
			default:
				next_state = S_OSC;
		endcase
		// A new edge in the clearing cycle survives
		if (irq_edge)
			next_ext_latch = 1'b1;
		// Pin reset restarts the timeout; ignored during oscillator start, while the
		// reset timeout runs or the core is already held waiting for the pin to rise
		if (!ext_reset_n && state != S_OSC && state != S_RST_TMO
			&& state != S_HOLD)
		begin
			tmr_start  = 1'b1;
			tmr_short  = !LONG_STARTUP;
			next_state = S_RST_TMO;
		end
		next_tmo_short  = tmr_start ? tmr_short : tmo_short;
		next_core_reset = next_state == S_OSC || next_state == S_RST_TMO
			|| next_state == S_HOLD;
		if (!ext_reset_n || next_core_reset)
		begin
			next_i_mask     = 1'b1;
			next_irq_vector = VEC_RESET;
			next_irq_take   = 1'b0;
			next_ext_latch  = 1'b0;
			next_stop_latch = 1'b0;
			next_wait_latch = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state      <= S_OSC;
			core_reset <= 1'b1;
			i_mask     <= 1'b1;
			irq_take   <= 1'b0;
			irq_vector <= VEC_RESET;
			ext_latch  <= 1'b0;
			stop_latch <= 1'b0;
			wait_latch <= 1'b0;
			core_sleep <= 1'b0;
			irq_q      <= 1'b1;
			tmo_short  <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			core_reset <= next_core_reset;
			i_mask     <= next_i_mask;
			irq_take   <= next_irq_take;
			irq_vector <= next_irq_vector;
			ext_latch  <= next_ext_latch;
			stop_latch <= next_stop_latch;
			wait_latch <= next_wait_latch;
			core_sleep <= next_stop_latch || next_wait_latch;
			irq_q      <= irq_n;
			tmo_short  <= next_tmo_short;
		end
	end

	// Constant presets that the core and peripherals load under core_reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stack_ptr_init     <= SP_RESET;
			tmr_counter_preset <= TMR_COUNTER_RESET;
			ddr_preset         <= DDR_RESET;
		end
		else
		begin
			stack_ptr_init     <= SP_RESET;
			tmr_counter_preset <= TMR_COUNTER_RESET;
			ddr_preset         <= DDR_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states

	logic              dp_write, next_dp_write;
	logic [ADDR_W-1:0] dp_addr, next_dp_addr;
	logic              ap;
	rsq_ctrl_t         next_ctrl;
	rsq_flags_t        next_flags, armed, next_armed;
	logic [31:0]       next_hrdata;

	always_comb
	begin
		ap            = hsel && hready && htrans[1];
		next_dp_write = ap && hwrite;
		next_dp_addr  = haddr[ADDR_W-1:0];
		next_ctrl     = ctrl;
		next_flags    = flags;
		next_armed    = armed;
		next_hrdata   = RDATA_NONE;
		if (dp_write && dp_addr == ADDR_CTRL)
		begin
			next_ctrl = rsq_ctrl_t'(hwdata[CTRL_W-1:0]);
			// Timer oscillator, once started, stays until reset
			next_ctrl.ext_timer_osc_enable = ctrl.ext_timer_osc_enable
				|| hwdata[CTRL_W-5];
		end
		if (ap && !hwrite)
			case (haddr[ADDR_W-1:0])
				ADDR_CTRL:   next_hrdata = 32'(ctrl);
				ADDR_FLAGS:  next_hrdata = 32'(flags);
				ADDR_STATUS: next_hrdata = 32'({tmr_busy, core_reset,
					wait_latch, stop_latch, ext_latch, i_mask, state});
				default:     next_hrdata = RDATA_NONE;
			endcase
		if (ap && !hwrite && haddr[ADDR_W-1:0] == ADDR_FLAGS)
			next_armed = flags;
		else if (ap && haddr[ADDR_W-1:0] == ADDR_ACK)
		begin
			next_flags = flags & ~armed;
			next_armed = FLAGS_RESET;
		end
		// Events set flags even with enables clear; set beats clear
		next_flags = next_flags | periph_events;
		if (!ext_reset_n || core_reset)
		begin
			next_ctrl  = CTRL_RESET;
			next_flags = FLAGS_RESET;
			next_armed = FLAGS_RESET;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_write  <= 1'b0;
			dp_addr   <= ADDR_CTRL;
			ctrl      <= CTRL_RESET;
			flags     <= FLAGS_RESET;
			armed     <= FLAGS_RESET;
			hrdata    <= RDATA_NONE;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			dp_write  <= next_dp_write;
			dp_addr   <= next_dp_addr;
			ctrl      <= next_ctrl;
			flags     <= next_flags;
			armed     <= next_armed;
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	logic [12:0] tmo_cnt;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tmo_cnt <= '0;
		else if (state == S_RST_TMO || state == S_STOP_TMO)
			tmo_cnt <= tmo_cnt + 13'h0001;
		else
			tmo_cnt <= '0;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_tmo_len;
		(state == S_RST_TMO || state == S_STOP_TMO) && tmr_done
			|-> tmo_cnt == (tmo_short ? 13'(TMO_SHORT_CYC) : 13'(LONG_CYC));
	endproperty
	a_tmo_len: assert property (p_tmo_len)
		else $error("startup timeout length wrong");

	property p_stop_short;
		state == S_STOP && stop_wake && ext_reset_n
			&& ctrl.short_startup_select |=> tmo_short;
	endproperty
	a_stop_short: assert property (p_stop_short)
		else $error("short startup not used on stop exit");

	property p_hold;
		state == S_RST_TMO && tmr_done && !ext_reset_n
			|=> core_reset && state == S_HOLD;
	endproperty
	a_hold: assert property (p_hold)
		else $error("core left reset while pin low");

	property p_pin_reset;
		!ext_reset_n |=> core_reset && i_mask && ctrl == CTRL_RESET
			&& !ext_latch && !stop_latch && irq_vector == VEC_RESET;
	endproperty
	a_pin_reset: assert property (p_pin_reset)
		else $error("pin reset did not restore state");

	property p_take_unmasked;
		irq_take && irq_vector != VEC_SWI |-> $past(!i_mask) && i_mask;
	endproperty
	a_take_unmasked: assert property (p_take_unmasked)
		else $error("masked request taken");

	property p_swi;
		state == S_RUN && ext_reset_n && !stop_enter && !rti_exec
			&& insn_boundary && swi_exec |=> irq_take && irq_vector == VEC_SWI;
	endproperty
	a_swi: assert property (p_swi)
		else $error("software trap not taken");

	property p_rti;
		state == S_RUN && ext_reset_n && !stop_enter && rti_exec
			|=> i_mask == $past(rti_stacked_i);
	endproperty
	a_rti: assert property (p_rti)
		else $error("mask not restored on return");

	property p_prio;
		irq_take && irq_vector != VEC_SWI && irq_vector != VEC_EXT
			|-> !$past(ext_latch);
	endproperty
	a_prio: assert property (p_prio)
		else $error("external request passed over");

	property p_keypad_enable;
		irq_take && irq_vector == VEC_KEYPAD |-> $past(ctrl.keypad_irq_enable);
	endproperty
	a_keypad_enable: assert property (p_keypad_enable)
		else $error("disabled keypad request taken");

	property p_flag_clear;
		ext_reset_n && !core_reset ##1 $fell(flags.transfer_done_flag)
			|-> $past(armed.transfer_done_flag);
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("flag cleared without status access");

	property p_ext_latch;
		ext_reset_n && !core_reset && !irq_n |=> ext_latch || irq_take;
	endproperty
	a_ext_latch: assert property (p_ext_latch)
		else $error("external request not latched");

	c_timer_take: cover property (irq_take && irq_vector == VEC_TIMER);
	c_stop_exit: cover property (state == S_STOP_TMO ##1 state == S_RUN);
	c_hold: cover property (state == S_HOLD ##1 state == S_RUN);
	c_flag_clear: cover property ($fell(flags.keypad_port_flag));

endmodule

//--- sim/reset_interrupt_sequencer_tb.sv
module reset_interrupt_sequencer_tb
	import rsq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LCYC = 8;

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        ext_reset_n, irq_n, osc_active;
	logic        insn_boundary, swi_exec, rti_exec, rti_stacked_i;
	logic        stop_enter, wait_enter, core_reset, i_mask, irq_take;
	logic        core_sleep;
	logic [12:0] irq_vector, stack_ptr_init;
	logic [15:0] tmr_counter_preset;
	logic [7:0]  ddr_preset;
	rsq_flags_t  periph_events, flags;
	rsq_ctrl_t   ctrl;
	logic [12:0] cv [4];
	logic [12:0] vec [4];
	int          errors, checked, cycles, n;

	rsq_top #(.LONG_STARTUP(1'b1), .LEVEL_IRQ(1'b1), .LONG_CYC(LCYC)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .ext_reset_n(ext_reset_n), .irq_n(irq_n),
		.osc_active(osc_active), .periph_events(periph_events),
		.insn_boundary(insn_boundary), .swi_exec(swi_exec),
		.rti_exec(rti_exec), .rti_stacked_i(rti_stacked_i),
		.stop_enter(stop_enter), .wait_enter(wait_enter),
		.core_reset(core_reset), .i_mask(i_mask), .irq_take(irq_take),
		.irq_vector(irq_vector), .core_sleep(core_sleep),
		.stack_ptr_init(stack_ptr_init),
		.tmr_counter_preset(tmr_counter_preset),
		.ddr_preset(ddr_preset), .ctrl(ctrl), .flags(flags)
	);

	rsq_core_model core (
		.hclk(hclk), .hresetn(hresetn), .irq_take(irq_take),
		.i_mask(i_mask), .insn_boundary(insn_boundary),
		.swi_exec(swi_exec), .rti_exec(rti_exec),
		.rti_stacked_i(rti_stacked_i), .stop_enter(stop_enter),
		.wait_enter(wait_enter), .periph_events(periph_events)
	);

	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Single word transfer; hold each phase until hready is seen high
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h00_0000, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// A hung handshake would stall the sequence forever
	initial
	begin
		cycles = 0;
		forever
		begin
			@(posedge hclk);
			cycles++;
			if (cycles == 5000)
			begin
				errors++;
				end_of_test();
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = '0;
		ext_reset_n = 1'b1;
		irq_n = 1'b1;
		osc_active = 1'b0;
		errors = 0;
		checked = 0;
		cv = '{13'h1FFF, 13'h1FFF, 13'h1FE3, 13'h1FA3};
		vec = '{VEC_EXT, VEC_TIMER, VEC_SERIAL, VEC_KEYPAD};
		repeat (20) @(posedge hclk);
		#1;
		check(32'(core_reset), 32'h0000_0001);
		check(32'(i_mask), 32'h0000_0001);
		check(32'(irq_vector), 32'(VEC_RESET));
		check(32'(stack_ptr_init), 32'(SP_RESET));
		check(32'(tmr_counter_preset), 32'(TMR_COUNTER_RESET));
		check(32'(ddr_preset), 32'(DDR_RESET));
		check(32'(ctrl), 32'h0000_0000);
		check(32'(flags), 32'h0000_0000);
		@(posedge hclk);
		hresetn <= 1'b1;
		// Control writes are refused while the core is held
		bus(1'b1, ADDR_CTRL, 32'h0000_1FFF);
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		check(32'(core_reset), 32'h0000_0001);
		@(posedge hclk);
		osc_active <= 1'b1;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
			#1;
		end
		while (core_reset !== 1'b0 && n < 100);
		check(32'(n), 32'(LCYC + 2));
		bus(1'b1, ADDR_CTRL, 32'h0000_1FFF);
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_1FFF);
		check(32'(ctrl), 32'h0000_1FFF);
		// The timer oscillator stays on once enabled
		bus(1'b1, ADDR_CTRL, 32'h0000_0000);
		bus(1'b0, ADDR_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0100);
		bus(1'b1, 8'h10, 32'hFFFF_FFFF);
		bus(1'b0, 8'h10, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		core.return_from_trap_instruction();
		#1;
		check(32'(i_mask), 32'h0000_0000);
		core.pulse(7'h7F, 1'b0, 1'b0);
		core.step(1'b0);
		#1;
		check(32'(irq_take), 32'h0000_0000);
		check(32'(flags), 32'h0000_007F);
		bus(1'b1, ADDR_ACK, 32'h0000_0000);
		bus(1'b0, ADDR_FLAGS, 32'h0000_0000);
		check(rd, 32'h0000_007F);
		core.step(1'b1);
		#1;
		check(32'(irq_take), 32'h0000_0001);
		check(32'(irq_vector), 32'(VEC_SWI));
		check(32'(i_mask), 32'h0000_0001);
		@(posedge hclk);
		irq_n <= 1'b0;
		repeat (2) @(posedge hclk);
		irq_n <= 1'b1;
		core.step(1'b1);
		#1;
		check(32'(irq_vector), 32'(VEC_SWI));
		core.return_from_trap_instruction();
		#1;
		check(32'(i_mask), 32'h0000_0001);
		core.return_from_trap_instruction();
		#1;
		check(32'(i_mask), 32'h0000_0000);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, ADDR_CTRL, 32'(cv[i]));
			core.step(1'b0);
			#1;
			check(32'(irq_take), 32'h0000_0001);
			check(32'(irq_vector), 32'(vec[i]));
			check(32'(i_mask), 32'h0000_0001);
			core.return_from_trap_instruction();
		end
		// Wait with a pending keypad request: taken with no boundary
		core.pulse(7'h00, 1'b0, 1'b1);
		#1;
		check(32'(core_sleep), 32'h0000_0001);
		@(posedge hclk);
		#1;
		check(32'(irq_take), 32'h0000_0001);
		check(32'(irq_vector), 32'(VEC_KEYPAD));
		check(32'(core_sleep), 32'h0000_0000);
		core.return_from_trap_instruction();
		bus(1'b0, ADDR_FLAGS, 32'h0000_0000);
		check(rd, 32'h0000_007F);
		bus(1'b1, ADDR_ACK, 32'h0000_0000);
		bus(1'b0, ADDR_FLAGS, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		core.pulse(7'h00, 1'b1, 1'b0);
		#1;
		check(32'(core_sleep), 32'h0000_0001);
		@(posedge hclk);
		irq_n <= 1'b0;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
			#1;
		end
		while (core_sleep !== 1'b0 && n < 50);
		check(32'(n), 32'(TMO_SHORT_CYC + 2));
		@(posedge hclk);
		irq_n <= 1'b1;
		core.pulse(7'h7F, 1'b0, 1'b0);
		@(posedge hclk);
		ext_reset_n <= 1'b0;
		repeat (LCYC + 6) @(posedge hclk);
		#1;
		check(32'(core_reset), 32'h0000_0001);
		check(32'(ctrl), 32'h0000_0000);
		check(32'(flags), 32'h0000_0000);
		check(32'(i_mask), 32'h0000_0001);
		@(posedge hclk);
		ext_reset_n <= 1'b1;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
			#1;
		end
		while (core_reset !== 1'b0 && n < 20);
		check(32'(n), 32'h0000_0001);
		bus(1'b0, ADDR_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0048);
		end_of_test();
	end
endmodule

//--- sim/rsq_core_model.sv
module rsq_core_model
	import rsq_pkg::*;
(
	input  wire logic  hclk,
	input  wire logic  hresetn,
	input  wire logic  irq_take,
	input  wire logic  i_mask,
	output logic       insn_boundary,
	output logic       swi_exec,
	output logic       rti_exec,
	output logic       rti_stacked_i,
	output logic       stop_enter,
	output logic       wait_enter,
	output rsq_flags_t periph_events
);
	timeunit 1ns;
	timeprecision 1ps;

	logic last_mask;
	logic frame_mask[$];

	initial
	begin
		insn_boundary = 1'b0;
		swi_exec = 1'b0;
		rti_exec = 1'b0;
		rti_stacked_i = 1'b0;
		stop_enter = 1'b0;
		wait_enter = 1'b0;
		periph_events = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// A frame keeps the mask as it stood before the take set it
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			frame_mask.delete();
			last_mask <= 1'b1;
		end
		else
		begin
			last_mask <= i_mask;
			if (irq_take)
				frame_mask.push_back(last_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic step(input logic software_trap_instruction);
		@(posedge hclk);
		insn_boundary <= 1'b1;
		swi_exec      <= software_trap_instruction;
		@(posedge hclk);
		insn_boundary <= 1'b0;
		swi_exec      <= 1'b0;
	endtask

	// An empty stack stands for a frame built by software with the mask clear
	task automatic return_from_trap_instruction();
		logic m;
		// Let the frame of a take that has just been flagged land first
		@(posedge hclk);
		#1;
		m = (frame_mask.size() > 0) ? frame_mask.pop_back() : 1'b0;
		@(posedge hclk);
		rti_exec      <= 1'b1;
		rti_stacked_i <= m;
		@(posedge hclk);
		rti_exec <= 1'b0;
	endtask

	task automatic pulse(input rsq_flags_t ev, input logic stp,
		input logic wt);
		@(posedge hclk);
		periph_events <= ev;
		stop_enter    <= stp;
		wait_enter    <= wt;
		@(posedge hclk);
		periph_events <= '0;
		stop_enter    <= 1'b0;
		wait_enter    <= 1'b0;
	endtask
endmodule
